//--- rtl/pfc_pkg.sv
package pfc_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 8;

  typedef enum logic [2:0] {
    PFC_CMD_READ,
    PFC_CMD_PROGRAM,
    PFC_CMD_SECTOR_ERASE,
    PFC_CMD_CHIP_ERASE,
    PFC_CMD_ID_ENTRY,
    PFC_CMD_ID_EXIT_SHORT,
    PFC_CMD_ID_EXIT_LONG,
    PFC_CMD_HW_ID_READ
  } pfc_cmd_t;

  typedef struct packed {
    pfc_cmd_t                cmd;
    logic [ADDR_W-1:0]       addr;
    logic [DATA_W-1:0]       data;
  } pfc_req_t;

  typedef struct packed {
    logic [DATA_W-1:0]       data;
    logic                    timeout;
  } pfc_rsp_t;

  typedef struct packed {
    logic                    ce_n;
    logic                    oe_n;
    logic                    we_n;
    logic                    id_hv;
    logic [ADDR_W-1:0]       addr;
    logic [DATA_W-1:0]       dq_out;
    logic                    dq_oe;
  } pfc_pins_t;

  // Command words and unlock addresses
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR_A = 18'h05555;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR_B = 18'h02aaa;
  localparam logic [DATA_W-1:0] UNLOCK_DATA_A = 8'haa;
  localparam logic [DATA_W-1:0] UNLOCK_DATA_B = 8'h55;
  localparam logic [DATA_W-1:0] CMD_BYTE_PROG = 8'ha0;
  localparam logic [DATA_W-1:0] CMD_BYTE_ERASE_SETUP = 8'h80;
  localparam logic [DATA_W-1:0] CMD_BYTE_SECTOR = 8'h30;
  localparam logic [DATA_W-1:0] CMD_BYTE_CHIP = 8'h10;
  localparam logic [DATA_W-1:0] CMD_BYTE_ID_ENTRY = 8'h90;
  localparam logic [DATA_W-1:0] CMD_BYTE_ID_EXIT = 8'hf0;
  localparam int SECTOR_LSB = 12;
  localparam int TOGGLE_BIT = 6;
  localparam int ID_SEL_BIT = 0;

  // Step indices of the last write in each sequence
  localparam logic [2:0] LAST_STEP_PROG  = 3'h3;
  localparam logic [2:0] LAST_STEP_ERASE = 3'h5;
  localparam logic [2:0] LAST_STEP_UNLK3 = 3'h2;
  localparam logic [2:0] LAST_STEP_ONE   = 3'h0;

  // Step indices of the two second-unlock writes and of the command write
  localparam logic [2:0] STEP_UNLOCK_B1  = 3'h1;
  localparam logic [2:0] STEP_UNLOCK_B2  = 3'h4;
  localparam logic [2:0] STEP_CMD        = 3'h2;

  // Bus timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_SETUP_NS    = 10;
  localparam int T_WP_NS       = 40;
  localparam int T_ACC_NS      = 100;
  localparam int T_HOLD_NS     = 20;
  localparam int SYNC_DEPTH    = 3;
  localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] WP_CYC    = CNT_W'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] ACC_CYC   = CNT_W'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_DEPTH);
  localparam logic [CNT_W-1:0] HOLD_CYC  = CNT_W'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_ONE   = 8'h01;

  localparam pfc_pins_t PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, id_hv: 1'b0,
                                      addr: '0, dq_out: '0, dq_oe: 1'b0};
endpackage

//--- rtl/pfc_bus_cycle.sv
`timescale 1ns/100ps
module pfc_bus_cycle (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  // Cycle request
  input  wire logic                       start,
  input  wire logic                       is_write,
  input  wire logic                       hv,
  input  wire logic [pfc_pkg::ADDR_W-1:0] addr,
  input  wire logic [pfc_pkg::DATA_W-1:0] wdata,
  // Cycle answer
  output logic                            done,
  output logic [pfc_pkg::DATA_W-1:0]      rdata,
  // Flash pins
  output pfc_pkg::pfc_pins_t              pins,
  input  wire logic [pfc_pkg::DATA_W-1:0] data_lines
);
  import pfc_pkg::*;

  typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_STROBE, BC_HOLD} pfc_bc_state_t;

  typedef struct packed {
    pfc_bc_state_t     st;
    logic              wr;
    logic [CNT_W-1:0]  cnt;
    logic [DATA_W-1:0] s1;
    logic [DATA_W-1:0] s2;
    logic [DATA_W-1:0] s3;
    logic              done;
    logic [DATA_W-1:0] rdata;
    pfc_pins_t         pins;
  } pfc_bc_t;

  localparam pfc_bc_t BC_RESET = '{st: BC_IDLE, wr: 1'b0, cnt: '0, s1: '0, s2: '0, s3: '0,
                                   done: 1'b0, rdata: '0, pins: PINS_IDLE};

  pfc_bc_t bc_reg;
  pfc_bc_t bc_next;

  always_comb begin
    bc_next      = bc_reg;
    bc_next.done = 1'b0;
    bc_next.s1   = data_lines;
    bc_next.s2   = bc_reg.s1;
    bc_next.s3   = bc_reg.s2;
    unique case (bc_reg.st)
      BC_IDLE: begin
        if (start) begin
          // Address, select and write data settle before any strobe edge
          bc_next.pins.addr   = addr;
          bc_next.pins.ce_n   = 1'b0;
          bc_next.pins.oe_n   = 1'b1;
          bc_next.pins.we_n   = 1'b1;
          bc_next.pins.id_hv  = hv;
          bc_next.pins.dq_out = wdata;
          bc_next.pins.dq_oe  = is_write;
          bc_next.wr          = is_write;
          bc_next.cnt         = SETUP_CYC;
          bc_next.st          = BC_SETUP;
        end
      end
      BC_SETUP: begin
        if (bc_reg.cnt > CNT_ONE) begin
          bc_next.cnt = bc_reg.cnt - CNT_ONE;
        end else if (bc_reg.wr) begin
          bc_next.pins.we_n = 1'b0;
          bc_next.cnt       = WP_CYC;
          bc_next.st        = BC_STROBE;
        end else begin
          bc_next.pins.oe_n = 1'b0;
          bc_next.cnt       = ACC_CYC;
          bc_next.st        = BC_STROBE;
        end
      end
      BC_STROBE: begin
        if (bc_reg.cnt > CNT_ONE) begin
          bc_next.cnt = bc_reg.cnt - CNT_ONE;
        end else if (bc_reg.wr) begin
          // Data keeps driving through the hold time after the rising strobe
          bc_next.pins.we_n = 1'b1;
          bc_next.cnt       = HOLD_CYC;
          bc_next.st        = BC_HOLD;
        end else if (bc_reg.s2 == bc_reg.s3) begin
          // Sample only once the synchronised byte is steady
          bc_next.rdata     = bc_reg.s3;
          bc_next.pins.oe_n = 1'b1;
          bc_next.cnt       = HOLD_CYC;
          bc_next.st        = BC_HOLD;
        end
      end
      BC_HOLD: begin
        if (bc_reg.cnt > CNT_ONE) begin
          bc_next.cnt = bc_reg.cnt - CNT_ONE;
        end else begin
          bc_next.pins.ce_n  = 1'b1;
          bc_next.pins.dq_oe = 1'b0;
          bc_next.pins.id_hv = 1'b0;
          bc_next.done       = 1'b1;
          bc_next.st         = BC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bc_reg <= BC_RESET;
    end else begin
      bc_reg <= bc_next;
    end
  end

  assign done  = bc_reg.done;
  assign rdata = bc_reg.rdata;
  assign pins  = bc_reg.pins;
endmodule

//--- rtl/pfc_host.sv
`timescale 1ns/100ps
module pfc_host #(
  parameter int POLL_LIMIT = 1000000
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  // Command port
  input  wire logic                       req_valid,
  input  pfc_pkg::pfc_req_t               req,
  output logic                            req_ready,
  output logic                            rsp_valid,
  output pfc_pkg::pfc_rsp_t               rsp,
  output logic                            busy,
  // Flash pins
  output pfc_pkg::pfc_pins_t              pins,
  input  wire logic [pfc_pkg::DATA_W-1:0] data_lines
);
  import pfc_pkg::*;

  generate
    if (POLL_LIMIT < 2) begin : g_bad_limit
      $error("POLL_LIMIT must allow at least two polling reads");
    end
  endgenerate

  typedef enum logic [2:0] {SQ_IDLE, SQ_ISSUE, SQ_WAIT, SQ_POLL, SQ_POLL_WAIT} pfc_sq_state_t;

  typedef struct packed {
    pfc_sq_state_t     st;
    pfc_req_t          op;
    logic [2:0]        step;
    logic [2:0]        last;
    logic              have_prev;
    logic              prev_tog;
    logic [31:0]       polls;
    logic              bc_start;
    logic              bc_write;
    logic              bc_hv;
    logic [ADDR_W-1:0] bc_addr;
    logic [DATA_W-1:0] bc_data;
    logic              req_ready;
    logic              rsp_valid;
    pfc_rsp_t          rsp;
    logic              busy;
  } pfc_sq_t;

  localparam pfc_sq_t SQ_RESET = '{st: SQ_IDLE, op: '0, step: '0, last: '0, have_prev: 1'b0,
                                   prev_tog: 1'b0, polls: '0, bc_start: 1'b0, bc_write: 1'b0,
                                   bc_hv: 1'b0, bc_addr: '0, bc_data: '0, req_ready: 1'b0,
                                   rsp_valid: 1'b0, rsp: '0, busy: 1'b0};
  localparam logic [31:0] POLL_MAX = 32'(POLL_LIMIT);

  pfc_sq_t           sq_reg;
  pfc_sq_t           sq_next;
  logic              bc_done;
  logic [DATA_W-1:0] bc_rdata;

  // ----------------------------------------------------------------
  // Sequence tables
  // ----------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] step_addr(input pfc_req_t op, input logic [2:0] idx);
    logic [ADDR_W-1:0] a;
    a = UNLOCK_ADDR_A;
    if (idx == STEP_UNLOCK_B1 || idx == STEP_UNLOCK_B2) begin
      a = UNLOCK_ADDR_B;
    end else if (op.cmd == PFC_CMD_PROGRAM && idx == LAST_STEP_PROG) begin
      a = op.addr;
    end else if (op.cmd == PFC_CMD_SECTOR_ERASE && idx == LAST_STEP_ERASE) begin
      a = {op.addr[ADDR_W-1:SECTOR_LSB], {SECTOR_LSB{1'b0}}};
    end else if (op.cmd == PFC_CMD_ID_EXIT_SHORT) begin
      a = op.addr;
    end
    return a;
  endfunction

  function automatic logic [DATA_W-1:0] step_data(input pfc_req_t op, input logic [2:0] idx);
    logic [DATA_W-1:0] d;
    d = UNLOCK_DATA_A;
    if (idx == STEP_UNLOCK_B1 || idx == STEP_UNLOCK_B2) begin
      d = UNLOCK_DATA_B;
    end else if (idx == STEP_CMD || op.cmd == PFC_CMD_ID_EXIT_SHORT) begin
      unique case (op.cmd)
        PFC_CMD_PROGRAM:       d = CMD_BYTE_PROG;
        PFC_CMD_SECTOR_ERASE,
        PFC_CMD_CHIP_ERASE:    d = CMD_BYTE_ERASE_SETUP;
        PFC_CMD_ID_ENTRY:      d = CMD_BYTE_ID_ENTRY;
        PFC_CMD_ID_EXIT_SHORT,
        PFC_CMD_ID_EXIT_LONG:  d = CMD_BYTE_ID_EXIT;
        default:               d = UNLOCK_DATA_A;
      endcase
    end else if (idx == LAST_STEP_PROG && op.cmd == PFC_CMD_PROGRAM) begin
      d = op.data;
    end else if (idx == LAST_STEP_ERASE) begin
      d = (op.cmd == PFC_CMD_CHIP_ERASE) ? CMD_BYTE_CHIP : CMD_BYTE_SECTOR;
    end
    return d;
  endfunction

  function automatic logic [2:0] last_step(input pfc_cmd_t cmd);
    logic [2:0] l;
    unique case (cmd)
      PFC_CMD_PROGRAM:                         l = LAST_STEP_PROG;
      PFC_CMD_SECTOR_ERASE, PFC_CMD_CHIP_ERASE: l = LAST_STEP_ERASE;
      PFC_CMD_ID_ENTRY, PFC_CMD_ID_EXIT_LONG:  l = LAST_STEP_UNLK3;
      default:                                 l = LAST_STEP_ONE;
    endcase
    return l;
  endfunction

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    sq_next           = sq_reg;
    sq_next.bc_start  = 1'b0;
    sq_next.rsp_valid = 1'b0;
    unique case (sq_reg.st)
      SQ_IDLE: begin
        sq_next.req_ready = 1'b1;
        sq_next.busy      = 1'b0;
        if (req_valid && sq_reg.req_ready) begin
          sq_next.op        = req;
          sq_next.step      = '0;
          sq_next.last      = last_step(req.cmd);
          sq_next.req_ready = 1'b0;
          sq_next.busy      = 1'b1;
          sq_next.st        = SQ_ISSUE;
        end
      end
      SQ_ISSUE: begin
        sq_next.bc_start = 1'b1;
        sq_next.st       = SQ_WAIT;
        if (sq_reg.op.cmd == PFC_CMD_READ) begin
          sq_next.bc_write = 1'b0;
          sq_next.bc_hv    = 1'b0;
          sq_next.bc_addr  = sq_reg.op.addr;
        end else if (sq_reg.op.cmd == PFC_CMD_HW_ID_READ) begin
          sq_next.bc_write = 1'b0;
          sq_next.bc_hv    = 1'b1;
          sq_next.bc_addr  = ADDR_W'(sq_reg.op.addr[ID_SEL_BIT]);
        end else begin
          // Sequences always go out whole and in table order
          sq_next.bc_write = 1'b1;
          sq_next.bc_hv    = 1'b0;
          sq_next.bc_addr  = step_addr(sq_reg.op, sq_reg.step);
          sq_next.bc_data  = step_data(sq_reg.op, sq_reg.step);
        end
      end
      SQ_WAIT: begin
        if (bc_done) begin
          if (!sq_reg.bc_write) begin
            sq_next.rsp_valid = 1'b1;
            sq_next.rsp       = '{data: bc_rdata, timeout: 1'b0};
            sq_next.st        = SQ_IDLE;
          end else if (sq_reg.step != sq_reg.last) begin
            sq_next.step = sq_reg.step + 3'h1;
            sq_next.st   = SQ_ISSUE;
          end else if (sq_reg.op.cmd inside {PFC_CMD_PROGRAM, PFC_CMD_SECTOR_ERASE, PFC_CMD_CHIP_ERASE}) begin
            // Stay busy and poll; no exit command can slip in meanwhile
            sq_next.have_prev = 1'b0;
            sq_next.polls     = '0;
            sq_next.bc_addr   = step_addr(sq_reg.op, sq_reg.last);
            sq_next.st        = SQ_POLL;
          end else begin
            // Identification entry or exit ends at once
            sq_next.rsp_valid = 1'b1;
            sq_next.rsp       = '{data: '0, timeout: 1'b0};
            sq_next.st        = SQ_IDLE;
          end
        end
      end
      SQ_POLL: begin
        sq_next.bc_start = 1'b1;
        sq_next.bc_write = 1'b0;
        sq_next.st       = SQ_POLL_WAIT;
      end
      SQ_POLL_WAIT: begin
        if (bc_done) begin
          sq_next.prev_tog  = bc_rdata[TOGGLE_BIT];
          sq_next.have_prev = 1'b1;
          sq_next.polls     = sq_reg.polls + 32'h1;
          if (sq_reg.have_prev && sq_reg.prev_tog == bc_rdata[TOGGLE_BIT]) begin
            sq_next.rsp_valid = 1'b1;
            sq_next.rsp       = '{data: bc_rdata, timeout: 1'b0};
            sq_next.st        = SQ_IDLE;
          end else if (sq_reg.polls + 32'h1 >= POLL_MAX) begin
            // Give up rather than hang on a dead part
            sq_next.rsp_valid = 1'b1;
            sq_next.rsp       = '{data: bc_rdata, timeout: 1'b1};
            sq_next.st        = SQ_IDLE;
          end else begin
            sq_next.st = SQ_POLL;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sq_reg <= SQ_RESET;
    end else begin
      sq_reg <= sq_next;
    end
  end

  pfc_bus_cycle u_bus (
    .clk           (clk),
    .reset_n       (reset_n),
    .start         (sq_reg.bc_start),
    .is_write      (sq_reg.bc_write),
    .hv            (sq_reg.bc_hv),
    .addr          (sq_reg.bc_addr),
    .wdata         (sq_reg.bc_data),
    .done          (bc_done),
    .rdata         (bc_rdata),
    .pins          (pins),
    .data_lines    (data_lines)
  );

  assign req_ready = sq_reg.req_ready;
  assign rsp_valid = sq_reg.rsp_valid;
  assign rsp       = sq_reg.rsp;
  assign busy      = sq_reg.busy;
endmodule

//--- sim/pfc_host_assertions.sv
`timescale 1ns/100ps
module pfc_host_assertions #(
  parameter int POLL_LIMIT = 1000000
) (
  // Clock and reset
  input wire logic                       clk,
  input wire logic                       reset_n,
  // Command port
  input wire logic                       req_valid,
  input pfc_pkg::pfc_req_t               req,
  input wire logic                       req_ready,
  input wire logic                       rsp_valid,
  input pfc_pkg::pfc_rsp_t               rsp,
  input wire logic                       busy,
  // Flash pins
  input pfc_pkg::pfc_pins_t              pins,
  input wire logic [pfc_pkg::DATA_W-1:0] data_lines
);
  import pfc_pkg::*;
  logic sect_reg;

  // ----------------------------------------
  // Helper: remembers a sector erase was taken
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      sect_reg <= 1'b0;
    else if (req_valid && req_ready)
      sect_reg <= req.cmd == PFC_CMD_SECTOR_ERASE;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_WRITE_LEVELS: assert property (!pins.we_n |-> pins.oe_n && !pins.ce_n && pins.dq_oe)
    else $error("write strobe without select or with gate low");
  AST_DRIVE_GATE_OFF: assert property (pins.dq_oe |-> pins.oe_n)
    else $error("host drives data while flash output enabled");
  AST_READ_LEVELS: assert property (!pins.oe_n |-> !pins.ce_n && pins.we_n && !pins.dq_oe)
    else $error("read with wrong control levels");
  AST_STROBE_WIDTH: assert property ($fell(pins.we_n) |-> (!pins.we_n)[*8] ##1 !pins.we_n ##1 !pins.we_n ##1 pins.we_n)
    else $error("write strobe width not ten cycles");
  AST_SETUP: assert property ($fell(pins.we_n) |-> $stable(pins.addr) && $stable(pins.dq_out) && $past(!pins.ce_n, 3))
    else $error("address or data not settled before strobe");
  AST_HOLD: assert property ($rose(pins.we_n) |-> $stable(pins.addr) ##1 (pins.dq_oe && !pins.ce_n && $stable(pins.dq_out))[*4])
    else $error("data not held after strobe");
  AST_HV_ADDR: assert property (pins.id_hv |-> pins.addr[17:1] == 17'h00000 && pins.we_n)
    else $error("supervoltage with nonzero upper address");
  AST_IDLE_DESELECT: assert property (!busy |-> pins.ce_n && !pins.id_hv)
    else $error("flash selected while idle");
  AST_READY_AFTER_RSP: assert property (rsp_valid |-> ##[0:1] req_ready)
    else $error("no new command accepted after response");
  AST_SECTOR_ADDR: assert property (sect_reg && !pins.we_n && pins.dq_out == CMD_BYTE_SECTOR |-> pins.addr[11:0] == 12'h000)
    else $error("sector erase low address bits not zero");
  AST_BUSY_REFUSES: assert property (busy |-> !req_ready)
    else $error("command port ready while an operation runs");
  AST_BUSY_ENDS: assert property (rsp_valid |-> busy ##1 !busy)
    else $error("busy does not drop right after the response");

  // Main scenarios
  cover property (rsp_valid && rsp.timeout);
  cover property (pins.id_hv && !pins.oe_n);
  cover property ($rose(pins.we_n) && pins.dq_out == CMD_BYTE_CHIP);
endmodule

bind pfc_host pfc_host_assertions #(.POLL_LIMIT(POLL_LIMIT)) u_chk (.clk(clk), .reset_n(reset_n),
  .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
  .busy(busy), .pins(pins), .data_lines(data_lines));

//--- sim/pfc_flash_model.sv
`timescale 1ns/100ps
module pfc_flash_model #(
  parameter logic [7:0] MFR_CODE   = 8'h3c, // Arbitrary value
  parameter logic [7:0] DEV_CODE   = 8'h5a, // Arbitrary value
  parameter int         FAST_READS = 2,
  parameter int         SLOW_READS = 20
) (
  // Control from bench
  input wire logic         slow,
  // Flash pins
  input pfc_pkg::pfc_pins_t pins,
  input wire logic [7:0]   data_lines,
  output logic [7:0]       drive_byte,
  output logic             dq_en
);
  import pfc_pkg::*;
  logic [7:0]  mem [int];
  logic [17:0] wa;
  logic [2:0]  step = 3'h0;
  logic        id_mode = 1'b0;
  logic        toggle, op_erase;
  logic [7:0]  op_data;
  int          busy_left = 0;

  task automatic go(input logic er, input logic [7:0] d);
    busy_left = slow ? SLOW_READS : FAST_READS;
    op_erase = er;
    op_data = d;
    toggle = 1'b1;
  endtask

  // ----------------------------------------
  // Command interpreter
  // ----------------------------------------
  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    logic ua, ub;
    int del[$];
    ua = a[14:0] == 15'h5555;
    ub = a[14:0] == 15'h2aaa;
    if (busy_left > 0) return;
    if (step == 3'h3) begin
      mem[a] = d;
      go(1'b0, d);
      step = 3'h0;
    end else if (step == 3'h6) begin
      foreach (mem[k]) if (d == 8'h30 && k[17:12] == a[17:12]) del.push_back(k);
      foreach (del[i]) mem.delete(del[i]);
      if (d == 8'h10 && ua) mem.delete();
      if (d == 8'h30 || (d == 8'h10 && ua)) go(1'b1, 8'hff);
      step = 3'h0;
    end else if (d == 8'haa && ua && (step == 3'h0 || step == 3'h4)) step = step + 3'h1;
    else if (d == 8'h55 && ub && (step == 3'h1 || step == 3'h5)) step = step + 3'h1;
    else if (step == 3'h2 && ua && d == 8'ha0) step = 3'h3;
    else if (step == 3'h2 && ua && d == 8'h80) step = 3'h4;
    else begin
      if (step == 3'h2 && ua && d == 8'h90) id_mode = 1'b1;
      if (d == 8'hf0 && (step == 3'h0 || (step == 3'h2 && ua))) id_mode = 1'b0;
      step = 3'h0;
    end
  endtask

  // Address at strobe fall, data at strobe rise; only a low strobe with select starts a write
  always @(negedge pins.we_n) if (!pins.ce_n) wa = pins.addr;
  always @(posedge pins.we_n) if (!pins.ce_n && pins.oe_n) wr(wa, data_lines);

  // ----------------------------------------
  // Reads
  // ----------------------------------------
  always @(negedge pins.oe_n) if (!pins.ce_n && pins.we_n) begin
    if (busy_left > 0) begin
      drive_byte = {op_erase ? 1'b0 : ~op_data[7], toggle, op_data[5:0]};
      toggle = ~toggle;
      busy_left--;
    end else if ((pins.id_hv && pins.addr[17:1] == 17'h00000) || id_mode)
      drive_byte = pins.addr[0] ? DEV_CODE : MFR_CODE;
    else
      drive_byte = mem.exists(pins.addr) ? mem[pins.addr] : 8'hff;
  end
  assign dq_en = !pins.ce_n && !pins.oe_n;
endmodule

//--- sim/test_pfc_host.sv
`timescale 1ns/100ps
module test_pfc_host;
  import pfc_pkg::*;
  localparam int         POLL_N = 8;
  localparam logic [7:0] MFR    = 8'h3c; // Arbitrary value
  localparam logic [7:0] DEV    = 8'h5a; // Arbitrary value
  typedef struct packed {logic [7:0] data; logic timeout; logic chk;} pfc_exp_t;
  logic        clk, reset_n, req_valid, req_ready, rsp_valid, busy, slow, dq_en, flt;
  pfc_req_t    req;
  pfc_rsp_t    rsp;
  pfc_pins_t   pins;
  logic [7:0]  drive_byte, data_lines, a_dat, b_dat;
  logic [17:0] a_addr, b_addr;
  pfc_exp_t    exp_q[$];
  pfc_exp_t    e;
  int          num_errors = 0, checked = 0, cycles = 0, seed;

  pfc_host #(.POLL_LIMIT(POLL_N)) u_dut (.clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .busy(busy), .pins(pins), .data_lines(data_lines));
  pfc_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_flash (.slow(slow), .pins(pins), .data_lines(data_lines),
    .drive_byte(drive_byte), .dq_en(dq_en));
  // Released lines show a pattern that flips each cycle, so stale data cannot pass
  assign data_lines = dq_en ? drive_byte : (pins.dq_oe ? pins.dq_out : {8{flt}});

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input logic [8:0] seen, input logic [8:0] expd);
    checked++;
    if (seen !== expd) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask

  task automatic print_verdict;
    $display("Checks %0d, errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------
  // Driver: offers one command, notes the expected answer, waits for it
  // ----------------------------------------
  task automatic cmd(input pfc_cmd_t c, input logic [17:0] a, input logic [7:0] d, input logic [7:0] xd,
                     input logic xt, input logic xc);
    @(negedge clk);
    req_valid = 1'b1;
    req = '{cmd: c, addr: a, data: d};
    exp_q.push_back(pfc_exp_t'{data: xd, timeout: xt, chk: xc});
    do @(posedge clk); while (req_ready !== 1'b1);
    @(negedge clk);
    req_valid = 1'b0;
    do @(posedge clk); while (rsp_valid !== 1'b1);
  endtask

  // ----------------------------------------
  // Monitor and timeout
  // ----------------------------------------
  always @(posedge clk) begin
    flt <= ~flt;
    cycles++;
    if (rsp_valid === 1'b1) begin
      // An unexpected response is made to mismatch on purpose
      if (exp_q.size() > 0) begin
        e = exp_q.pop_front();
      end else begin
        e = pfc_exp_t'{data: ~rsp.data, timeout: ~rsp.timeout, chk: 1'b1};
      end
      check({rsp.data & {8{e.chk}}, rsp.timeout}, {e.data & {8{e.chk}}, e.timeout});
    end
    if (cycles == 60000) begin
      num_errors++;
      print_verdict;
    end
  end

  initial begin
    seed = 32'ha7e8;
    reset_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    slow = 1'b0;
    flt = 1'b0;
    a_addr = {6'h11, 12'($random(seed))};
    b_addr = {6'h22, 12'($random(seed))};
    a_dat = {1'b0, 7'($random(seed))};
    b_dat = {1'b0, 7'($random(seed))};
    repeat (20) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    cmd(PFC_CMD_HW_ID_READ, 18'h00000, 8'h00, MFR, 1'b0, 1'b1);
    cmd(PFC_CMD_HW_ID_READ, 18'h00001, 8'h00, DEV, 1'b0, 1'b1);
    cmd(PFC_CMD_READ, a_addr, 8'h00, 8'hff, 1'b0, 1'b1);
    cmd(PFC_CMD_PROGRAM, a_addr, a_dat, a_dat, 1'b0, 1'b1);
    cmd(PFC_CMD_PROGRAM, b_addr, b_dat, b_dat, 1'b0, 1'b1);
    cmd(PFC_CMD_READ, a_addr, 8'h00, a_dat, 1'b0, 1'b1);
    cmd(PFC_CMD_ID_ENTRY, 18'h00000, 8'h00, 8'h00, 1'b0, 1'b1);
    cmd(PFC_CMD_READ, 18'h00001, 8'h00, DEV, 1'b0, 1'b1);
    cmd(PFC_CMD_ID_EXIT_SHORT, b_addr, 8'h00, 8'h00, 1'b0, 1'b1);
    cmd(PFC_CMD_READ, a_addr, 8'h00, a_dat, 1'b0, 1'b1);
    cmd(PFC_CMD_ID_ENTRY, 18'h00000, 8'h00, 8'h00, 1'b0, 1'b1);
    cmd(PFC_CMD_READ, 18'h00000, 8'h00, MFR, 1'b0, 1'b1);
    cmd(PFC_CMD_ID_EXIT_LONG, 18'h00000, 8'h00, 8'h00, 1'b0, 1'b1);
    cmd(PFC_CMD_READ, b_addr, 8'h00, b_dat, 1'b0, 1'b1);
    cmd(PFC_CMD_SECTOR_ERASE, {a_addr[17:12], 12'($random(seed))}, 8'h00, 8'hff, 1'b0, 1'b1);
    cmd(PFC_CMD_READ, a_addr, 8'h00, 8'hff, 1'b0, 1'b1);
    cmd(PFC_CMD_READ, b_addr, 8'h00, b_dat, 1'b0, 1'b1);
    cmd(PFC_CMD_CHIP_ERASE, b_addr, 8'h00, 8'hff, 1'b0, 1'b1);
    cmd(PFC_CMD_READ, b_addr, 8'h00, 8'hff, 1'b0, 1'b1);
    slow = 1'b1;
    cmd(PFC_CMD_PROGRAM, b_addr, b_dat, 8'h00, 1'b1, 1'b0);
    // Let the monitor finish the last comparison before the verdict
    @(negedge clk);
    if (exp_q.size() != 0) begin
      num_errors++;
    end
    print_verdict;
  end
endmodule
